// >>> refresh_interval_timer.sv
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "refresh_timer_defines.svh"
module refresh_interval_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // events
  output logic refreshRequest,
  output logic matchInterrupt,
  output refresh_timer_pkg::mode_t timerMode
);
  import refresh_timer_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic matchFlag;
  logic matchIrqEnable;
  logic [2:0] tickSourceSelect;
  logic [7:0] tickCounter;
  logic [7:0] matchConstant;
  logic dynamicRamConnectEnable;
  logic pseudoStaticConnectEnable;
  logic softwareStandby;
  logic hardwareStandby;
  logic flagSeenSet;
  logic swStandbyDelayed;
  logic hwStandbyDelayed;
  logic locked;
  logic standbyEntry;
  logic anyStandbyEntry;
  logic [7:0] next_count;
  logic matchNow;
  bus_state_t busState;
  logic [11:0] dataAddr;
  logic dataWrite;
  logic wrStatus;
  logic wrCount;
  logic wrConstant;
  logic wrConnect;
  logic wrStandby;
  logic rdStatus;
  logic [31:0] readMux;
  logic addrPhase;

  tick_if tk ();

  tick_prescaler u_prescaler (
    .clk(clk),
    .rst_b(rst_b),
    .tk(tk)
  );

  assign tk.tickSourceSelect = tickSourceSelect;
  assign tk.clearPrescale = softwareStandby | hardwareStandby;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  assign locked = dynamicRamConnectEnable | pseudoStaticConnectEnable;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timerMode <= MODE_INTERVAL;
    end else begin
      case ({pseudoStaticConnectEnable, dynamicRamConnectEnable})
        2'b00: timerMode <= MODE_INTERVAL;
        2'b01: timerMode <= MODE_DYNAMIC;
        2'b10: timerMode <= MODE_PSEUDO;
        default: timerMode <= MODE_ILLEGAL;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite address and data phase
  // ---------------------------------------------------------------
  assign addrPhase = hsel & hready & htrans[1];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busState <= BUS_IDLE;
      dataAddr <= 12'h000;
      dataWrite <= 1'b0;
    end else if (hready) begin
      busState <= addrPhase ? BUS_DATA : BUS_IDLE;
      dataAddr <= haddr;
      dataWrite <= hwrite;
    end
  end

  always_comb begin
    wrStatus = 1'b0;
    wrCount = 1'b0;
    wrConstant = 1'b0;
    wrConnect = 1'b0;
    wrStandby = 1'b0;
    if (busState == BUS_DATA && dataWrite) begin
      case (dataAddr)
        `OFS_CTRL_STATUS: wrStatus = 1'b1;
        `OFS_COUNT: wrCount = 1'b1;
        `OFS_CONSTANT: wrConstant = 1'b1;
        `OFS_MEM_CONNECT: wrConnect = 1'b1;
        `OFS_STANDBY: wrStandby = 1'b1;
        default: wrStatus = 1'b0;
      endcase
    end
  end

  // read data is fetched in the address phase and registered
  // a read straight after a write to the same word sees the old value
  always_comb begin
    case (haddr)
      `OFS_CTRL_STATUS: readMux = {24'h000000, matchFlag, matchIrqEnable,
                                   tickSourceSelect, `LOW_BITS_READ};
      `OFS_COUNT: readMux = {24'h000000, tickCounter};
      `OFS_CONSTANT: readMux = {24'h000000, matchConstant};
      `OFS_MEM_CONNECT: readMux = {30'h0, pseudoStaticConnectEnable,
                                   dynamicRamConnectEnable};
      `OFS_STANDBY: readMux = {30'h0, hardwareStandby, softwareStandby};
      default: readMux = 32'h00000000;
    endcase
  end

  assign rdStatus = addrPhase & ~hwrite & (haddr == `OFS_CTRL_STATUS);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= readMux;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // connect enables and standby controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dynamicRamConnectEnable <= 1'b0;
      pseudoStaticConnectEnable <= 1'b0;
    end else if (hardwareStandby) begin
      dynamicRamConnectEnable <= 1'b0;
      pseudoStaticConnectEnable <= 1'b0;
    end else if (wrConnect) begin
      dynamicRamConnectEnable <= hwdata[`BIT_DYN_ENABLE];
      pseudoStaticConnectEnable <= hwdata[`BIT_PSEUDO_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      softwareStandby <= 1'b0;
      hardwareStandby <= 1'b0;
    end else if (wrStandby) begin
      softwareStandby <= hwdata[`BIT_SW_STANDBY];
      hardwareStandby <= hwdata[`BIT_HW_STANDBY];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      swStandbyDelayed <= 1'b0;
      hwStandbyDelayed <= 1'b0;
    end else begin
      swStandbyDelayed <= softwareStandby;
      hwStandbyDelayed <= hardwareStandby;
    end
  end

  assign standbyEntry = hardwareStandby & ~hwStandbyDelayed;
  assign anyStandbyEntry = standbyEntry | (softwareStandby & ~swStandbyDelayed);

  // ---------------------------------------------------------------
  // counter and compare
  // ---------------------------------------------------------------
  always_comb begin
    next_count = tickCounter;
    if (tk.tick) begin
      next_count = tickCounter + 8'h01;
    end
  end

  // no compare while the prescaler is held in standby
  assign matchNow = tk.tick && !tk.clearPrescale && (next_count == matchConstant);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCounter <= `COUNT_RESET;
    end else if (softwareStandby || hardwareStandby || anyStandbyEntry) begin
      tickCounter <= `COUNT_RESET;
    end else if (matchNow) begin
      tickCounter <= `COUNT_RESET;
    end else if (wrCount && !locked) begin
      tickCounter <= hwdata[7:0];
    end else begin
      tickCounter <= next_count;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      matchConstant <= `CONSTANT_RESET;
    end else if (hardwareStandby) begin
      matchConstant <= `CONSTANT_RESET;
    end else if (wrConstant && !locked) begin
      matchConstant <= hwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // control/status register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flagSeenSet <= 1'b0;
    end else if (rdStatus) begin
      flagSeenSet <= matchFlag;
    end else if (wrStatus) begin
      flagSeenSet <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      matchFlag <= 1'b0;
    end else if (softwareStandby || hardwareStandby) begin
      matchFlag <= 1'b0;
    end else if (matchNow) begin
      matchFlag <= 1'b1;
    end else if (wrStatus && flagSeenSet && !hwdata[`BIT_MATCH_FLAG]) begin
      matchFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      matchIrqEnable <= 1'b0;
    end else if (locked || softwareStandby || hardwareStandby) begin
      matchIrqEnable <= 1'b0;
    end else if (wrStatus) begin
      matchIrqEnable <= hwdata[`BIT_IRQ_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickSourceSelect <= `SRC_RESET;
    end else if (hardwareStandby) begin
      tickSourceSelect <= `SRC_RESET;
    end else if (wrStatus && !locked) begin
      tickSourceSelect <= hwdata[`SRC_MSB:`SRC_LSB];
    end
  end

  // ---------------------------------------------------------------
  // event outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refreshRequest <= 1'b0;
    end else begin
      refreshRequest <= matchNow & locked;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      matchInterrupt <= 1'b0;
    end else begin
      matchInterrupt <= (matchFlag | matchNow) & matchIrqEnable & ~locked;
    end
  end
endmodule // refresh_interval_timer

// >>> refresh_timer_defines.svh
`ifndef REFRESH_TIMER_DEFINES_SVH
`define REFRESH_TIMER_DEFINES_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL_STATUS 12'h000
`define OFS_COUNT 12'h004
`define OFS_CONSTANT 12'h008
`define OFS_MEM_CONNECT 12'h00C
`define OFS_STANDBY 12'h010

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BIT_MATCH_FLAG 7
`define BIT_IRQ_ENABLE 6
`define SRC_MSB 5
`define SRC_LSB 3
`define BIT_DYN_ENABLE 0
`define BIT_PSEUDO_ENABLE 1
`define BIT_SW_STANDBY 0
`define BIT_HW_STANDBY 1

// ---------------------------------------------------------------
// reset values and the fixed read value of the status low bits
// ---------------------------------------------------------------
`define COUNT_RESET 8'h00
`define CONSTANT_RESET 8'hFF
`define SRC_RESET 3'h0
`define LOW_BITS_READ 3'h7

// ---------------------------------------------------------------
// timing counts: prescaler width covers divide by 4096
// ---------------------------------------------------------------
`define PRESCALE_WIDTH 12

`endif

// >>> refresh_timer_pkg.sv
package refresh_timer_pkg;

  typedef enum logic [1:0] {
    MODE_INTERVAL,
    MODE_DYNAMIC,
    MODE_PSEUDO,
    MODE_ILLEGAL
  } mode_t;

  typedef enum logic [2:0] {
    SRC_STOP,
    SRC_DIV2,
    SRC_DIV8,
    SRC_DIV32,
    SRC_DIV128,
    SRC_DIV512,
    SRC_DIV2048,
    SRC_DIV4096
  } tick_source_t;

  typedef enum {
    BUS_IDLE,
    BUS_DATA
  } bus_state_t;

endpackage

// >>> tick_if.sv
`timescale 1ns/1ps
interface tick_if;
  logic [2:0] tickSourceSelect;
  logic clearPrescale;
  logic tick;
  modport source (input tickSourceSelect, input clearPrescale, output tick);
  modport sink (output tickSourceSelect, output clearPrescale, input tick);
endinterface // tick_if

// >>> tick_prescaler.sv
`timescale 1ns/1ps
`include "refresh_timer_defines.svh"
module tick_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // tick selection
  tick_if.source tk
);
  import refresh_timer_pkg::*;

  logic [`PRESCALE_WIDTH-1:0] divCount;
  logic [`PRESCALE_WIDTH-1:0] nextDivCount;
  logic [7:0] tapWrap;

  assign nextDivCount = divCount + `PRESCALE_WIDTH'(1);

  // ---------------------------------------------------------------
  // free-running divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCount <= '0;
    end else if (tk.clearPrescale) begin
      divCount <= '0;
    end else begin
      divCount <= nextDivCount;
    end
  end

  // ---------------------------------------------------------------
  // one-cycle pulse when the chosen low bits wrap
  // ---------------------------------------------------------------
  assign tapWrap[0] = 1'b0;
  genvar g;
  generate
    for (g = 1; g < 8; g++) begin : g_tap
      localparam int W = (g == 7) ? 12 : 2 * g - 1;
      assign tapWrap[g] = &divCount[W-1:0];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tk.tick <= 1'b0;
    end else begin
      tk.tick <= tapWrap[tk.tickSourceSelect] & ~tk.clearPrescale;
    end
  end
endmodule // tick_prescaler

// >>> refresh_timer_monitor.sv
`timescale 1ns/1ps
module refresh_timer_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // events
  input wire logic refreshRequest,
  input wire logic matchInterrupt,
  input wire refresh_timer_pkg::mode_t timerMode
);
  import refresh_timer_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // write tracking
  // ---------------------------------------------------------------
  logic take;
  logic wrPend;
  logic [11:0] wrAddr;
  logic [1:0] connVal;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend <= 1'b0;
      wrAddr <= 12'h000;
      connVal <= 2'h0;
    end else begin
      wrPend <= take && hwrite;
      wrAddr <= haddr;
      if (wrPend) begin
        connVal <= hwdata[1:0];
      end
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_status_ones: assert property (take && !hwrite && haddr == 12'h000 |=>
    hrdata[2:0] == 3'h7 && hrdata[31:8] == 24'h000000)
    else $error("status low bits not ones");
  a_unmapped_zero: assert property (take && !hwrite && haddr > 12'h010 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_mode: assert property (matchInterrupt |->
    timerMode == MODE_INTERVAL || $past(timerMode) == MODE_INTERVAL)
    else $error("interrupt outside interval mode");
  a_refresh_mode: assert property (refreshRequest |->
    timerMode != MODE_INTERVAL || $past(timerMode) != MODE_INTERVAL)
    else $error("refresh request in interval mode");
  a_refresh_pulse: assert property (refreshRequest |=> !refreshRequest)
    else $error("refresh request longer than one cycle");
  a_mode_decode: assert property (wrPend && wrAddr == 12'h00C |=> ##[0:2] timerMode == connVal)
    else $error("mode does not follow connect enables");
  a_irq_disable: assert property (wrPend && wrAddr == 12'h000 && !hwdata[6] |=>
    ##[0:1] !matchInterrupt)
    else $error("interrupt stays with enable cleared");
  a_standby_quiet: assert property (wrPend && wrAddr == 12'h010 && hwdata[1:0] != 2'h0 |=>
    ##2 !matchInterrupt [*3])
    else $error("interrupt during standby");
endmodule // refresh_timer_monitor

bind refresh_interval_timer refresh_timer_monitor u_refresh_timer_monitor (.clk, .rst_b,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .refreshRequest, .matchInterrupt, .timerMode);

// >>> refresh_cycle_model.sv
`timescale 1ns/1ps
module refresh_cycle_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // request from timer
  input wire logic refreshRequest,
  // served refreshes
  output int refreshCount
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refreshCount <= 0;
    end else if (refreshRequest) begin
      refreshCount <= refreshCount + 1;
    end
  end
endmodule // refresh_cycle_model

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
  import refresh_timer_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic refreshRequest;
  logic matchInterrupt;
  mode_t timerMode;
  int refreshCount;
  int err_count = 0;
  int compares = 0;
  int p;
  int n0;
  logic [31:0] rdv;
  logic [31:0] rdw;
  refresh_interval_timer u_refresh_interval_timer (.clk(clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .refreshRequest(refreshRequest), .matchInterrupt(matchInterrupt), .timerMode(timerMode));
  refresh_cycle_model u_refresh_cycle_model (.clk(clk), .rst_b(rst_b),
    .refreshRequest(refreshRequest), .refreshCount(refreshCount));
  initial begin
    forever #10 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // bus and closing tasks
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    xfer(0, 12'h000, 0);
    `CHK(rdv, 32'h07)
    xfer(0, 12'h004, 0);
    `CHK(rdv, 32'h00)
    xfer(0, 12'h008, 0);
    `CHK(rdv, 32'hFF)
    xfer(0, 12'h014, 0);
    // tick rate of every source code over three periods
    for (int n = 0; n < 8; n++) begin
      p = (n == 0) ? 8 : (n == 7) ? 4096 : (1 << (2 * n - 1));
      xfer(1, 12'h000, n << 3);
      xfer(1, 12'h004, 0);
      xfer(0, 12'h004, 0);
      rdw = rdv;
      repeat (3 * p - 3) @(posedge clk);
      xfer(0, 12'h004, 0);
      `CHK(rdv - rdw, (n == 0) ? 32'h0 : 32'h3)
    end
    // flag, clear protocol and interrupt enable
    xfer(1, 12'h008, 32'h20);
    xfer(1, 12'h000, 32'h48);
    n0 = 0;
    while (matchInterrupt !== 1'b1 && n0 < 200) begin
      @(posedge clk);
      n0++;
    end
    `CHK(matchInterrupt, 1'b1)
    xfer(1, 12'h000, 32'h40);
    xfer(0, 12'h000, 0);
    `CHK(rdv, 32'hC7)
    xfer(1, 12'h000, 32'h80);
    repeat (2) @(posedge clk);
    `CHK(matchInterrupt, 1'b0)
    xfer(0, 12'h000, 0);
    `CHK(rdv, 32'h87)
    xfer(1, 12'h000, 32'h00);
    xfer(0, 12'h000, 0);
    `CHK(rdv, 32'h07)
    xfer(1, 12'h000, 32'h08);
    // connect enable decode
    for (int i = 0; i < 4; i++) begin
      xfer(1, 12'h00C, i);
      repeat (2) @(posedge clk);
      `CHK(timerMode, mode_t'(i))
    end
    // dynamic ram mode: lock and refresh
    xfer(1, 12'h00C, 32'h1);
    xfer(1, 12'h008, 32'h80);
    xfer(1, 12'h000, 32'h78);
    xfer(1, 12'h004, 32'hF0);
    xfer(0, 12'h004, 0);
    `CHK(rdv < 32'h20, 1'b1)
    xfer(0, 12'h008, 0);
    `CHK(rdv, 32'h20)
    xfer(0, 12'h000, 0);
    `CHK(rdv & 32'h7F, 32'h0F)
    n0 = refreshCount;
    repeat (256) @(posedge clk);
    `CHK(refreshCount - n0, 4)
    while (refreshRequest !== 1'b1) @(posedge clk);
    xfer(0, 12'h000, 0);
    `CHK(rdv[7], 1'b1)
    xfer(1, 12'h000, 32'h00);
    xfer(0, 12'h000, 0);
    `CHK(rdv[7], 1'b0)
    // software then hardware standby
    xfer(1, 12'h010, 32'h1);
    xfer(0, 12'h004, 0);
    `CHK(rdv, 32'h00)
    xfer(0, 12'h000, 0);
    `CHK(rdv, 32'h0F)
    xfer(0, 12'h008, 0);
    `CHK(rdv, 32'h20)
    xfer(1, 12'h010, 32'h2);
    xfer(0, 12'h008, 0);
    `CHK(rdv, 32'hFF)
    xfer(0, 12'h000, 0);
    `CHK(rdv, 32'h07)
    `CHK(timerMode, MODE_INTERVAL)
    xfer(1, 12'h010, 32'h0);
    // interval interrupt cut by software standby
    xfer(1, 12'h008, 32'h20);
    xfer(1, 12'h000, 32'h48);
    n0 = 0;
    while (matchInterrupt !== 1'b1 && n0 < 200) begin
      @(posedge clk);
      n0++;
    end
    `CHK(matchInterrupt, 1'b1)
    xfer(1, 12'h010, 32'h1);
    repeat (3) @(posedge clk);
    `CHK(matchInterrupt, 1'b0)
    xfer(0, 12'h000, 0);
    `CHK(rdv, 32'h0F)
    xfer(1, 12'h010, 32'h0);
    end_of_test();
  end
endmodule // tb_top
